// ===== design/pbf_pkg.sv
// constants shared by the physical-layer / buffer-layer interface block
// assumes a single core clock domain and a decoded control-symbol port on the link side
package pbf_pkg;

   // ****************************************************************
   // widths
   // ****************************************************************
   localparam int ACK_W  = 6;
   localparam int BST_W  = 6;
   localparam int DAT_W  = 16;
   localparam int TDAT_W = 32;
   localparam int REG_W  = 32;
   localparam int ADR_W  = 2;
   localparam int CST_W  = 3;

   // ****************************************************************
   // ack id values
   // ****************************************************************
   localparam logic [ACK_W-1:0] ACK_ZERO       = 6'h00;
   localparam logic [ACK_W-1:0] LAST_RST_SHORT = 6'h1F;
   localparam logic [ACK_W-1:0] LAST_RST_LONG  = 6'h3F;
   localparam logic [ACK_W-1:0] STEP_SHORT     = 6'h02;
   localparam logic [ACK_W-1:0] STEP_LONG      = 6'h01;
   localparam logic [ACK_W-1:0] SHORT_MASK     = 6'h3E;
   localparam logic [BST_W-1:0] BST_NONE       = 6'h00;

   // ****************************************************************
   // control symbol codes on the decoded symbol ports
   // ****************************************************************
   localparam logic [CST_W-1:0] CS_ACCEPTED  = 3'h0;
   localparam logic [CST_W-1:0] CS_RETRY     = 3'h1;
   localparam logic [CST_W-1:0] CS_NOT_ACC   = 3'h2;
   localparam logic [CST_W-1:0] CS_STATUS    = 3'h3;
   localparam logic [CST_W-1:0] CS_LINK_RESP = 3'h4;

   // ****************************************************************
   // software registers: index on the plain register port
   // ****************************************************************
   localparam logic [ADR_W-1:0] REG_CTRL = 2'h0;
   localparam logic [ADR_W-1:0] REG_ACK  = 2'h1;
   localparam logic [ADR_W-1:0] REG_BUF  = 2'h2;
   localparam int CTRL_LONG_BIT  = 0;
   localparam int ACK_NEXT_LSB   = 0;
   localparam int ACK_LAST_LSB   = 8;
   localparam int ACK_REWIND_BIT = 16;
   localparam int BUF_REMOTE_LSB = 0;
   localparam int BUF_LOCAL_LSB  = 8;
   localparam logic CTRL_LONG_RST = 1'b0;

   // ****************************************************************
   // state types
   // ****************************************************************
   typedef enum logic [1:0] {RX_IDLE, RX_PKT, RX_DROP} pbf_rx_type;
   typedef enum logic [1:0] {TX_RUN, TX_RETRY_STOP, TX_ERR_STOP} pbf_tx_type;

endpackage : pbf_pkg

// ===== design/pbf_phy_buf_if.sv
// physical-layer side of the buffer interface: flow counts, crc stripping, discontinues, ack ids
// assumes link-side decoders and the buffer layer share CLK; link beats cannot be stalled
//
// Our own choices: the placing of the registers and the address-and-strobe port.
module pbf_phy_buf_if
   import pbf_pkg::*;
(
   input  wire logic              CLK,
   input  wire logic              NRST,
   // register port
   input  wire logic [ADR_W-1:0]  REG_ADDR,
   input  wire logic [REG_W-1:0]  REG_WDATA,
   input  wire logic              REG_WR,
   input  wire logic              REG_RD,
   output logic      [REG_W-1:0]  REG_RDATA,
   // buffer layer flow counts and ack ids
   input  wire logic [BST_W-1:0]  LOCAL_BUF_STAT,
   output logic      [BST_W-1:0]  REMOTE_BUF_STAT,
   output logic      [ACK_W-1:0]  NEXT_TRANSMIT_ACK_ID,
   output logic      [ACK_W-1:0]  LAST_ACK_ID,
   output logic                   REWIND,
   // receive stream to buffer layer
   output logic                   M_AXIS_TVALID,
   input  wire logic              M_AXIS_TREADY,
   output logic      [DAT_W-1:0]  M_AXIS_TDATA,
   output logic                   M_AXIS_TLAST,
   output logic                   M_AXIS_TUSER,
   // transmit stream from buffer layer
   input  wire logic              S_AXIS_TVALID,
   output logic                   S_AXIS_TREADY,
   input  wire logic [TDAT_W-1:0] S_AXIS_TDATA,
   input  wire logic              S_AXIS_TLAST,
   input  wire logic              S_AXIS_TUSER,
   // received packet halfwords from the link decoder
   input  wire logic              LNK_RX_VALID,
   input  wire logic [DAT_W-1:0]  LNK_RX_DATA,
   input  wire logic              LNK_RX_LAST,
   input  wire logic              LNK_RX_ICRC,
   input  wire logic              LNK_RX_FCRC,
   input  wire logic              LNK_RX_USERDEF,
   input  wire logic              LNK_RX_ERR,
   // transmit beats to the link encoder
   output logic                   LNK_TX_VALID,
   output logic      [TDAT_W-1:0] LNK_TX_DATA,
   output logic                   LNK_TX_LAST,
   output logic      [ACK_W-1:0]  LNK_TX_ACKID,
   output logic                   LNK_TX_STOMP,
   // decoded incoming control symbols
   input  wire logic              CS_RX_VALID,
   input  wire logic [CST_W-1:0]  CS_RX_TYPE,
   input  wire logic [ACK_W-1:0]  CS_RX_ACKID,
   input  wire logic [BST_W-1:0]  CS_RX_BUFSTAT,
   input  wire logic              CS_RX_ERR,
   // outgoing control symbol requests
   output logic                   CS_TX_VALID,
   output logic      [CST_W-1:0]  CS_TX_TYPE,
   output logic      [ACK_W-1:0]  CS_TX_ACKID,
   output logic      [BST_W-1:0]  CS_TX_BUFSTAT
);

   // ****************************************************************
   // declarations
   // ****************************************************************
   logic             long_r;
   logic [ACK_W-1:0] next_r, last_r, rx_ack_r, ack_mask, ack_step;
   logic             rewind_r, tx_sent_r, tready_r;
   pbf_tx_type       tx_st_r;
   pbf_rx_type       rx_st_r;
   logic             hold_v_r;
   logic [DAT_W-1:0] hold_d_r;
   logic             cs_ok, tx_beat, tx_end, tx_abort, rx_keep, rx_full, rx_bad;
   logic             mode_wr;

   assign ack_mask = long_r ? 6'h3F : SHORT_MASK;
   assign ack_step = long_r ? STEP_LONG : STEP_SHORT;
   assign cs_ok    = CS_RX_VALID && !CS_RX_ERR;
   assign tx_beat  = S_AXIS_TVALID && tready_r;
   assign tx_end   = tx_beat && S_AXIS_TLAST;
   assign tx_abort = tx_end && S_AXIS_TUSER;
   assign mode_wr  = REG_WR && REG_ADDR == REG_CTRL;
   // crc and pad halfwords are flagged by the decoder; last halfword is never payload
   assign rx_keep  = !LNK_RX_ICRC && !(LNK_RX_FCRC && !LNK_RX_USERDEF)
                     && !(LNK_RX_USERDEF && LNK_RX_LAST);
   assign rx_full  = M_AXIS_TVALID && !M_AXIS_TREADY;
   assign rx_bad   = LNK_RX_ERR || (rx_full && rx_keep && hold_v_r);

   // ****************************************************************
   // register port
   // ****************************************************************
   // mode register; any write re-seeds the next and last ack ids, but not the receive ack id
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         long_r <= CTRL_LONG_RST;
      end else if (mode_wr) begin
         long_r <= REG_WDATA[CTRL_LONG_BIT];
      end
   end

   // read data valid only the cycle after the read strobe
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         REG_RDATA <= '0;
      end else begin
         REG_RDATA <= '0;
         if (REG_RD) begin
            unique case (REG_ADDR)
               REG_CTRL: REG_RDATA[CTRL_LONG_BIT] <= long_r;
               REG_ACK: begin
                  REG_RDATA[ACK_NEXT_LSB +: ACK_W] <= next_r;
                  REG_RDATA[ACK_LAST_LSB +: ACK_W] <= last_r;
                  REG_RDATA[ACK_REWIND_BIT]        <= rewind_r;
               end
               REG_BUF: begin
                  REG_RDATA[BUF_REMOTE_LSB +: BST_W] <= REMOTE_BUF_STAT;
                  REG_RDATA[BUF_LOCAL_LSB +: BST_W]  <= LOCAL_BUF_STAT;
               end
               default: REG_RDATA <= '0;                            // unmapped index reads zero
            endcase
         end
      end
   end

   // ****************************************************************
   // transmit ack id tracking and restart request
   // ****************************************************************
   // recovery state: retry stops until the buffer layer closes its packet
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         tx_st_r <= TX_RUN;
      end else if (cs_ok && CS_RX_TYPE == CS_RETRY) begin
         tx_st_r <= TX_RETRY_STOP;
      end else if (cs_ok && CS_RX_TYPE == CS_NOT_ACC) begin
         tx_st_r <= TX_ERR_STOP;
      end else if (tx_st_r == TX_RETRY_STOP && tx_end) begin
         tx_st_r <= TX_RUN;
      end else if (tx_st_r == TX_ERR_STOP && cs_ok && CS_RX_TYPE == CS_LINK_RESP) begin
         tx_st_r <= TX_RUN;
      end
   end

   // restart request; a new cause in the closing cycle wins over the clear
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         rewind_r <= 1'b0;
      end else if (cs_ok && (CS_RX_TYPE == CS_RETRY || CS_RX_TYPE == CS_NOT_ACC)) begin
         rewind_r <= 1'b1;
      end else if (tx_end) begin
         rewind_r <= 1'b0;
      end
   end

   // next ack id: advance on a good end, hold on abort, reload on recovery
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         next_r <= ACK_ZERO;
      end else if (mode_wr) begin
         next_r <= ACK_ZERO;
      end else if (cs_ok && (CS_RX_TYPE == CS_RETRY || CS_RX_TYPE == CS_LINK_RESP)) begin
         next_r <= CS_RX_ACKID & ack_mask;
      end else if (tx_end && !tx_abort && !rewind_r) begin
         next_r <= next_r + ack_step;
      end
   end

   // last acknowledged id; errored symbols leave it alone
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         last_r <= LAST_RST_SHORT;
      end else if (mode_wr) begin
         last_r <= REG_WDATA[CTRL_LONG_BIT] ? LAST_RST_LONG : LAST_RST_SHORT;
      end else if (cs_ok && CS_RX_TYPE == CS_ACCEPTED) begin
         last_r <= CS_RX_ACKID & ack_mask;
      end else if (cs_ok && CS_RX_TYPE == CS_LINK_RESP) begin
         last_r <= (CS_RX_ACKID - ack_step) & ack_mask;
      end
   end

   // remote free count from accepted, retry and status symbols
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         REMOTE_BUF_STAT <= BST_NONE;
      end else if (cs_ok && (CS_RX_TYPE == CS_ACCEPTED || CS_RX_TYPE == CS_RETRY
                             || CS_RX_TYPE == CS_STATUS)) begin
         REMOTE_BUF_STAT <= CS_RX_BUFSTAT;
      end
   end

   assign NEXT_TRANSMIT_ACK_ID = next_r;
   assign LAST_ACK_ID          = last_r;
   assign REWIND               = rewind_r;
   assign S_AXIS_TREADY        = tready_r;

   // ****************************************************************
   // transmit stream forwarding
   // ****************************************************************
   // ready stays high so the closing beat always arrives; beats under rewind are dropped
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         tready_r <= 1'b0;
      end else begin
         tready_r <= 1'b1;
      end
   end

   // forward beats with the ack id header; stomp a partly sent aborted packet
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         LNK_TX_VALID <= 1'b0;
         LNK_TX_DATA  <= '0;
         LNK_TX_LAST  <= 1'b0;
         LNK_TX_ACKID <= ACK_ZERO;
         LNK_TX_STOMP <= 1'b0;
         tx_sent_r    <= 1'b0;
      end else begin
         LNK_TX_VALID <= tx_beat && !rewind_r && !tx_abort;
         LNK_TX_DATA  <= S_AXIS_TDATA;
         LNK_TX_LAST  <= tx_end;
         LNK_TX_ACKID <= next_r;
         LNK_TX_STOMP <= (tx_abort || (tx_end && rewind_r)) && tx_sent_r;
         if (tx_end) begin
            tx_sent_r <= 1'b0;
         end else if (tx_beat && !rewind_r) begin
            tx_sent_r <= 1'b1;
         end
      end
   end

   // ****************************************************************
   // receive path: crc stripping, discard and abort
   // ****************************************************************
   // one halfword is held back so the payload end can be marked once crc is dropped
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         rx_st_r       <= RX_IDLE;
         hold_v_r      <= 1'b0;
         hold_d_r      <= '0;
         M_AXIS_TVALID <= 1'b0;
         M_AXIS_TDATA  <= '0;
         M_AXIS_TLAST  <= 1'b0;
         M_AXIS_TUSER  <= 1'b0;
      end else begin
         if (M_AXIS_TVALID && M_AXIS_TREADY) begin
            M_AXIS_TVALID <= 1'b0;
         end
         if (LNK_RX_VALID) begin
            unique case (rx_st_r)
               RX_IDLE, RX_PKT: begin
                  if (rx_st_r == RX_IDLE && LOCAL_BUF_STAT == BST_NONE) begin
                     rx_st_r <= LNK_RX_LAST ? RX_IDLE : RX_DROP;
                  end else if (rx_bad) begin
                     // abort beat replaces any stuck beat; the packet is void anyway
                     M_AXIS_TVALID <= 1'b1;
                     M_AXIS_TDATA  <= hold_d_r;
                     M_AXIS_TLAST  <= 1'b1;
                     M_AXIS_TUSER  <= 1'b1;
                     hold_v_r      <= 1'b0;
                     rx_st_r       <= LNK_RX_LAST ? RX_IDLE : RX_DROP;
                  end else if (LNK_RX_LAST) begin
                     M_AXIS_TVALID <= hold_v_r;
                     M_AXIS_TDATA  <= hold_d_r;
                     M_AXIS_TLAST  <= 1'b1;
                     M_AXIS_TUSER  <= 1'b0;
                     hold_v_r      <= 1'b0;
                     rx_st_r       <= RX_IDLE;
                  end else begin
                     rx_st_r <= RX_PKT;
                     if (rx_keep) begin
                        M_AXIS_TVALID <= hold_v_r;
                        M_AXIS_TDATA  <= hold_d_r;
                        M_AXIS_TLAST  <= 1'b0;
                        M_AXIS_TUSER  <= 1'b0;
                        hold_v_r      <= 1'b1;
                        hold_d_r      <= LNK_RX_DATA;
                     end
                  end
               end
               RX_DROP: begin
                  if (LNK_RX_LAST) begin
                     rx_st_r <= RX_IDLE;
                  end
               end
               default: rx_st_r <= RX_IDLE;
            endcase
         end
      end
   end

   // ****************************************************************
   // outgoing control symbols for received packets
   // ****************************************************************
   // every symbol carries the buffer layer's free count as sampled now
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         CS_TX_VALID   <= 1'b0;
         CS_TX_TYPE    <= CS_ACCEPTED;
         CS_TX_ACKID   <= ACK_ZERO;
         CS_TX_BUFSTAT <= BST_NONE;
         rx_ack_r      <= ACK_ZERO;
      end else begin
         CS_TX_VALID   <= 1'b0;
         CS_TX_ACKID   <= rx_ack_r;
         CS_TX_BUFSTAT <= LOCAL_BUF_STAT;
         if (LNK_RX_VALID && rx_st_r != RX_DROP) begin
            if (rx_st_r == RX_IDLE && LOCAL_BUF_STAT == BST_NONE) begin
               CS_TX_VALID <= 1'b1;
               CS_TX_TYPE  <= CS_RETRY;
            end else if (rx_bad) begin
               CS_TX_VALID <= 1'b1;
               CS_TX_TYPE  <= LNK_RX_ERR ? CS_NOT_ACC : CS_RETRY;
            end else if (LNK_RX_LAST) begin
               CS_TX_VALID <= 1'b1;
               CS_TX_TYPE  <= CS_ACCEPTED;
               rx_ack_r    <= (rx_ack_r + ack_step) & ack_mask;
            end
         end
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking ck @(posedge CLK); endclocking
   default disable iff (!NRST);

   sequence retry_in_s;
      cs_ok && CS_RX_TYPE == CS_RETRY;
   endsequence
   sequence empty_start_s;
      LNK_RX_VALID && rx_st_r == RX_IDLE && LOCAL_BUF_STAT == BST_NONE;
   endsequence

   rewind_held_a: assert property (rewind_r && !tx_end |=> rewind_r)
      else $error("restart request dropped before end of packet");
   retry_reload_a: assert property (retry_in_s |=> rewind_r && next_r == ($past(CS_RX_ACKID) & ack_mask))
      else $error("retry did not reload next ack id");
   accept_load_a: assert property (cs_ok && CS_RX_TYPE == CS_ACCEPTED && !mode_wr
                                   |=> last_r == ($past(CS_RX_ACKID) & ack_mask))
      else $error("accepted symbol did not load last ack id");
   err_hold_a: assert property (CS_RX_VALID && CS_RX_ERR && !mode_wr |=> $stable(last_r))
      else $error("errored symbol changed last ack id");
   abort_hold_a: assert property (tx_abort && !CS_RX_VALID && !mode_wr |=> $stable(next_r))
      else $error("aborted packet advanced next ack id");
   short_even_a: assert property (!long_r && !$past(mode_wr) |-> !next_r[0])
      else $error("short mode next ack id is odd");
   advance_a: assert property (tx_end && !tx_abort && !rewind_r && !CS_RX_VALID && !mode_wr
                               |=> next_r == $past(next_r) + $past(ack_step))
      else $error("next ack id did not step");
   empty_retry_a: assert property (empty_start_s |=> CS_TX_VALID && CS_TX_TYPE == CS_RETRY
                                   && !$rose(M_AXIS_TVALID) ##0 CS_TX_BUFSTAT == BST_NONE)
      else $error("empty buffer did not answer with retry");
   err_stop_a: assert property (cs_ok && CS_RX_TYPE == CS_NOT_ACC |=> tx_st_r == TX_ERR_STOP && rewind_r)
      else $error("not-accepted symbol did not enter error recovery");
   rx_abort_a: assert property (LNK_RX_VALID && LNK_RX_ERR && rx_st_r == RX_PKT
                                |=> M_AXIS_TVALID && M_AXIS_TLAST && M_AXIS_TUSER)
      else $error("receive error not aborted to buffer layer");

endmodule // pbf_phy_buf_if

// ===== sim/pbf_buf_model.sv
// buffer layer model: sinks the receive stream, sends one-beat transmit packets
// assumes the block's clock and reset; the testbench pulses send
module pbf_buf_model
   import pbf_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              nrst,
   input  wire logic              send,
   input  wire logic              rewind,
   input  wire logic              m_valid,
   input  wire logic [DAT_W-1:0]  m_data,
   input  wire logic              m_last,
   input  wire logic              m_user,
   output logic                   m_ready,
   output logic                   s_valid,
   output logic      [TDAT_W-1:0] s_data,
   output logic                   s_user,
   input  wire logic              s_ready,
   output logic      [7:0]        rx_n,
   output logic      [DAT_W-1:0]  rx_d,
   output logic                   rx_ab
);
   timeunit 1ns;
   timeprecision 100ps;
   // always ready: the link side cannot be stalled, and there is no abort path back
   assign m_ready = 1'b1;
   // record beats; an abort mark tells the bench the packet is to be thrown away
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rx_n <= 8'h00;
         rx_d <= 16'h0000;
         rx_ab <= 1'b0;
      end else if (m_valid && m_ready) begin
         rx_n <= rx_n + 8'h01;
         rx_d <= m_data;
         rx_ab <= m_last && m_user;
      end
   end
   // one-beat packets held until ready; idle data toggles so no stale value shows
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_valid <= 1'b0;
         s_data <= 32'h00000000;
         s_user <= 1'b0;
      end else if (s_valid && s_ready) begin
         s_valid <= 1'b0;
      end else if (send && !s_valid) begin
         s_valid <= 1'b1;
         s_user <= rewind;
         s_data <= 32'h5A5A0001;
      end else if (!s_valid) begin
         s_data <= ~s_data;
      end
   end
endmodule // pbf_buf_model

// ===== sim/pbf_phy_buf_if_tb.sv
// bench for the physical/buffer interface: symbols, both streams, registers
// assumes the design package and the buffer model are compiled first
module pbf_phy_buf_if_tb
   import pbf_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [5:0] LV [3] = '{6'h01, 6'h1E, 6'h3F};
   logic              clk, nrst, reg_wr, reg_rd, send, rx_v, rx_l, rx_i, rx_f, rx_u, rx_e, cs_v, cs_e;
   logic              rewind, m_v, m_r, m_l, m_u, s_v, s_u, s_r, tx_v, tx_l, tx_s, co_v, rx_ab, tx_lc;
   logic [ADR_W-1:0]  reg_addr;
   logic [REG_W-1:0]  reg_wdata, reg_rdata, rv;
   logic [BST_W-1:0]  local_bst, remote_bst, cs_b, co_b, co_bc;
   logic [ACK_W-1:0]  next_id, last_id, tx_id, tx_ic, cs_a, co_a, co_ac;
   logic [CST_W-1:0]  cs_t, co_t, co_tc;
   logic [DAT_W-1:0]  rx_d, m_d, rx_dd;
   logic [TDAT_W-1:0] s_d, tx_d, tx_dc;
   logic [7:0]        rx_n, tx_n, n0, st_n;
   int                mismatches, checks;
   always #2.5 clk = ~clk;
   pbf_phy_buf_if dut_u (.CLK(clk), .NRST(nrst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
      .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .LOCAL_BUF_STAT(local_bst), .REMOTE_BUF_STAT(remote_bst),
      .NEXT_TRANSMIT_ACK_ID(next_id), .LAST_ACK_ID(last_id), .REWIND(rewind), .M_AXIS_TVALID(m_v),
      .M_AXIS_TREADY(m_r), .M_AXIS_TDATA(m_d), .M_AXIS_TLAST(m_l), .M_AXIS_TUSER(m_u), .S_AXIS_TVALID(s_v),
      .S_AXIS_TREADY(s_r), .S_AXIS_TDATA(s_d), .S_AXIS_TLAST(1'b1), .S_AXIS_TUSER(s_u), .LNK_RX_VALID(rx_v),
      .LNK_RX_DATA(rx_dd), .LNK_RX_LAST(rx_l), .LNK_RX_ICRC(rx_i), .LNK_RX_FCRC(rx_f), .LNK_RX_USERDEF(rx_u),
      .LNK_RX_ERR(rx_e), .LNK_TX_VALID(tx_v), .LNK_TX_DATA(tx_d), .LNK_TX_LAST(tx_l), .LNK_TX_ACKID(tx_id),
      .LNK_TX_STOMP(tx_s), .CS_RX_VALID(cs_v), .CS_RX_TYPE(cs_t), .CS_RX_ACKID(cs_a), .CS_RX_BUFSTAT(cs_b),
      .CS_RX_ERR(cs_e), .CS_TX_VALID(co_v), .CS_TX_TYPE(co_t), .CS_TX_ACKID(co_a), .CS_TX_BUFSTAT(co_b));
   pbf_buf_model bm_u (.clk(clk), .nrst(nrst), .send(send), .rewind(rewind), .m_valid(m_v), .m_data(m_d),
      .m_last(m_l), .m_user(m_u), .m_ready(m_r), .s_valid(s_v), .s_data(s_d), .s_user(s_u), .s_ready(s_r),
      .rx_n(rx_n), .rx_d(rx_d), .rx_ab(rx_ab));
   // link pulses stand one cycle, so latch them as they pass
   always @(posedge clk) begin
      if (tx_v) tx_n <= tx_n + 8'h01;
      if (tx_v) tx_ic <= tx_id;
      if (tx_v) tx_dc <= tx_d;
      if (tx_v) tx_lc <= tx_l;
      if (tx_s) st_n <= st_n + 8'h01;
      if (co_v) co_ac <= co_a;
      if (co_v) co_tc <= co_t;
      if (co_v) co_bc <= co_b;
   end
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // incoming symbol is a one-cycle pulse; outputs settle the cycle after
   task automatic sym(input logic [CST_W-1:0] t, input logic [ACK_W-1:0] a, input logic [BST_W-1:0] b, input e);
      @(posedge clk);
      {cs_v, cs_t, cs_a, cs_b, cs_e} <= {1'b1, t, a, b, e};
      @(posedge clk);
      cs_v <= 1'b0;
      cyc(1);
   endtask
   // one register cycle; read data is taken in the cycle after the strobe
   task automatic acc(input logic w, input logic [ADR_W-1:0] a, input logic [REG_W-1:0] d);
      @(posedge clk);
      {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, d};
      @(posedge clk);
      {reg_wr, reg_rd} <= 2'h0;
      #1 rv = reg_rdata;
   endtask
   task automatic rxb(input logic [DAT_W-1:0] d, input logic [3:0] f);
      @(posedge clk);
      {rx_v, rx_dd, rx_i, rx_f, rx_l, rx_e} <= {1'b1, d, f};
   endtask
   // three halfwords: payload, flagged halfword, trailing pad; idle data inverted
   task automatic pkt(input logic [3:0] f);
      n0 = rx_n;
      rxb(16'hA1A1, 4'h0);
      rxb(16'hB2B2, f);
      rxb(16'hFFFF, 4'h6);
      @(posedge clk);
      {rx_v, rx_dd, rx_i, rx_f, rx_l, rx_e} <= {1'b0, ~rx_dd, 4'h0};
      cyc(5);
   endtask
   task automatic go();
      @(posedge clk);
      send <= 1'b1;
      @(posedge clk);
      send <= 1'b0;
      cyc(6);
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // watchdog: the whole sequence needs well under a microsecond per scenario
   initial begin
      #50000;
      mismatches++;
      finish_test();
   end
   initial begin
      {clk, nrst, reg_wr, reg_rd, send, rx_v, rx_l, rx_i, rx_f, rx_u, rx_e, cs_v, cs_e} = '0;
      {reg_addr, reg_wdata, cs_t, cs_a, cs_b, rx_dd, tx_n, st_n} = '0;
      {mismatches, checks, local_bst} = {32'h0, 32'h0, 6'h03};
      cyc(4);
      nrst = 1'b1;
      check("next id", next_id, ACK_ZERO);
      check("last id", last_id, LAST_RST_SHORT);
      acc(1'b0, REG_ACK, '0);
      check("ack reg", rv, 32'h00001F00);
      acc(1'b0, 2'h3, '0);
      check("unmapped reg", rv, 32'h0);
      sym(CS_STATUS, 6'h00, 6'h1E, 1'b0);
      check("remote status", remote_bst, 6'h1E);
      sym(CS_STATUS, 6'h00, 6'h3F, 1'b0);
      check("remote flow", remote_bst, 6'h3F);
      sym(CS_ACCEPTED, 6'h00, 6'h05, 1'b0);
      check("remote accept", remote_bst, 6'h05);
      acc(1'b0, REG_BUF, '0);
      check("buf reg", rv, 32'h00000305);
      check("last accept", last_id, ACK_ZERO);
      sym(CS_ACCEPTED, 6'h02, 6'h09, 1'b1);
      check("last errored", last_id, ACK_ZERO);
      go();
      check("tx ack id", tx_ic, ACK_ZERO);
      check("tx data", tx_dc, 32'h5A5A0001);
      check("tx last", tx_lc, 1'b1);
      check("next step", next_id, STEP_SHORT);
      sym(CS_RETRY, 6'h02, 6'h04, 1'b0);
      check("rewind retry", rewind, 1'b1);
      check("next retry", next_id, 6'h02);
      go();
      check("rewind clear", rewind, 1'b0);
      check("abort next", next_id, 6'h02);
      check("abort dropped", tx_n, 8'h01);
      check("no stomp unsent", st_n, 8'h00);
      go();
      check("resent id", tx_ic, 6'h02);
      sym(CS_NOT_ACC, 6'h04, 6'h04, 1'b0);
      check("rewind refused", rewind, 1'b1);
      go();
      // minimal, counted and receiver-flow values all reach the outgoing symbol
      foreach (LV[i]) begin
         local_bst <= LV[i];
         pkt(4'h8);
         check("rx beats", rx_n - n0, 8'h01);
         check("rx data", rx_d, 16'hA1A1);
         check("ack type", co_tc, CS_ACCEPTED);
         check("ack bufstat", co_bc, LV[i]);
         check("ack id out", co_ac, i * STEP_SHORT);
      end
      local_bst <= 6'h00;
      pkt(4'h0);
      check("full beats", rx_n - n0, 8'h00);
      check("full type", co_tc, CS_RETRY);
      local_bst <= 6'h03;
      rx_u <= 1'b1;
      pkt(4'h4);
      check("user beats", rx_n - n0, 8'h02);
      check("user crc kept", rx_d, 16'hB2B2);
      rx_u <= 1'b0;
      pkt(4'h1);
      check("rx abort", rx_ab, 1'b1);
      check("error type", co_tc, CS_NOT_ACC);
      acc(1'b1, REG_CTRL, 32'h1);
      check("long last", last_id, LAST_RST_LONG);
      go();
      check("long step", next_id, STEP_LONG);
      finish_test();
   end
endmodule // pbf_phy_buf_if_tb
